// *** ssld_top.sv ***
// Top of the serial shift latch driver: input sampling and shift chain.
`timescale 1ns/1ps
`include "ssld_defs.svh"

// Summary of operation
// R01: Twelve shift stages feed twelve storage cells and twelve output gates, one per line.
// R02: The chain moves only on a rising shift-clock edge and otherwise holds every stage.
// R03: On each rising edge every stage takes its predecessor and the first takes serial data.
// R04: While the transfer input is high each storage cell passes its shift stage.
// R05: While the transfer input is low the cells keep the value held when it fell.
// R06: A high gating input forces all line driver outputs low, a low one passes the cells.
// R07: The cascade output always shows the final shift stage.
// R08: Any unconnected controller input is taken as high; mclk, clk_en and nrst have no presence flag.
// R09: The controller shifts twelve bits per device, last output first, before opening the cells.
module ssld_top
	import ssld_pkg::*;
#(
	parameter int WIDTH = `SSLD_STAGES
) (
	// Clock, enable and reset
	input  wire logic             mclk,
	input  wire logic             clk_en,
	input  wire logic             nrst,
	// Controller inputs, each with a presence flag for floating pins
	input  wire logic             shift_clk,
	input  wire logic             shift_clk_conn,
	input  wire logic             serial_in,
	input  wire logic             serial_in_conn,
	input  wire logic             latch_xfer,
	input  wire logic             latch_xfer_conn,
	input  wire logic             gate_n,
	input  wire logic             gate_n_conn,
	// Outputs
	output logic [WIDTH-1:0]      line_driver_out,
	output logic                  cascade_out
);
	// --------------------------------------------------------------
	// Reset release
	// --------------------------------------------------------------
	// Reset leaves through two flip-flops so the chain starts on an mclk edge, never between.
	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_sync <= `SSLD_SYNC_RST;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// --------------------------------------------------------------
	// Input levels
	// --------------------------------------------------------------
	// A floating pin reads high, as the pull-up clamp on each input would make it.
	wire clk_lvl  = shift_clk_conn  ? shift_clk  : 1'b1; // R08
	wire data_lvl = serial_in_conn  ? serial_in  : 1'b1; // R08
	wire xfer_lvl = latch_xfer_conn ? latch_xfer : 1'b1; // R08
	wire gate_lvl = gate_n_conn     ? gate_n     : 1'b1; // R08

	// --------------------------------------------------------------
	// Timing limits
	// --------------------------------------------------------------
	// The shift clock is sampled, not used as a clock, so each of its high and low
	// phases must span at least one enabled mclk edge or a pulse is missed.
	// Serial data is taken at the same mclk edge that first sees the clock high,
	// so it must be settled by then and may change right after.
	// Outputs follow an open cell without waiting for mclk; transparency was chosen
	// over glitch-free outputs because the cells must pass the stages while open.

	// --------------------------------------------------------------
	// Shift chain
	// --------------------------------------------------------------
	logic [WIDTH-1:0] shift_stage;
	logic [WIDTH-1:0] next_shift_stage;
	logic             clk_prev;
	wire              clk_rise = clk_lvl && !clk_prev;

	// The previous clock level starts high so a pin already high at reset is no edge.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clk_prev <= 1'b1;
		end else if (clk_en) begin
			clk_prev <= clk_lvl;
		end
	end

	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_stage
			if (i == 0) begin : g_first
				assign next_shift_stage[i] = clk_rise ? data_lvl : shift_stage[i]; // R03
				step_first_a: assert property (@(posedge mclk) disable iff (!rst_n) // R03
					(clk_en && clk_rise) |=> shift_stage[i] == $past(data_lvl))
					else $error("First stage did not take the serial input.");
			end else begin : g_rest
				assign next_shift_stage[i] = clk_rise ? shift_stage[i-1] : shift_stage[i]; // R03
				step_bit_a: assert property (@(posedge mclk) disable iff (!rst_n) // R03
					(clk_en && clk_rise) |=> shift_stage[i] == $past(shift_stage[i-1]))
					else $error("Stage did not take its predecessor.");
			end
		end
	endgenerate

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_stage <= WIDTH'(`SSLD_STAGE_RST);
		end else if (clk_en) begin
			shift_stage <= next_shift_stage; // R02
		end
	end

	wire final_shift_stage = shift_stage[WIDTH-1];
	assign cascade_out = final_shift_stage; // R07

	// --------------------------------------------------------------
	// Storage cells and gates
	// --------------------------------------------------------------
	ssld_if #(.WIDTH(WIDTH)) lnk ();
	assign lnk.stage      = shift_stage;
	assign lnk.latch_open = xfer_lvl;
	assign lnk.gate_n     = gate_lvl;
	assign line_driver_out = lnk.drive; // R01

	ssld_latch #(.WIDTH(WIDTH)) ssld_latch_inst (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.lnk    (lnk.latch)
	);

	// --------------------------------------------------------------
	// Reset checks
	// --------------------------------------------------------------
	// Checked without a disable so that a reset that fails to clear the chain is seen.
	reset_clear_a: assert property (@(posedge mclk) // R07
		!rst_n |-> (shift_stage == WIDTH'(`SSLD_STAGE_RST) && cascade_out == 1'b0))
		else $error("Chain not cleared during reset.");

	// --------------------------------------------------------------
	// Shift chain checks
	// --------------------------------------------------------------
	// The detector leaves reset high, so a clock pin already high then is no edge.
	first_level_a: assert property (@(posedge mclk) disable iff (!rst_n) // R02
		$rose(rst_n) |-> clk_prev)
		else $error("Edge detector left reset low.");
	no_edge_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // R02
		(clk_en && !clk_rise) |=> shift_stage == $past(shift_stage))
		else $error("Stages changed without a clock edge.");
	shift_step_a: assert property (@(posedge mclk) disable iff (!rst_n) // R03
		(clk_en && clk_rise) |=>
		shift_stage == {$past(shift_stage[WIDTH-2:0]), $past(data_lvl)})
		else $error("Stages did not shift by one.");
	// A clock held high shifts once; the detector must not fire again on the level.
	single_rise_a: assert property (@(posedge mclk) disable iff (!rst_n) // R02
		(clk_en && clk_rise) |=> !clk_rise)
		else $error("Held clock level shifted twice.");
	// A low enable freezes the detector too, so a clock that rises during it and stays high shifts once it ends.
	freeze_chain_a: assert property (@(posedge mclk) disable iff (!rst_n) // R02
		!clk_en |=> (shift_stage == $past(shift_stage) && clk_prev == $past(clk_prev)))
		else $error("Chain moved while the enable was low.");
	cascade_tap_a: assert property (@(posedge mclk) disable iff (!rst_n) // R07
		cascade_out == shift_stage[WIDTH-1])
		else $error("Cascade output not the final stage.");
	// The cascade pin only moves on a shift, whatever the transfer and gating inputs do.
	cascade_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // R07
		!(clk_en && clk_rise) |=> $stable(cascade_out))
		else $error("Cascade output moved without a shift.");

	// --------------------------------------------------------------
	// Storage and gate checks
	// --------------------------------------------------------------
	// Open cells show the chain in the same cycle, before any mclk edge.
	open_follow_a: assert property (@(posedge mclk) disable iff (!rst_n) // R04
		(xfer_lvl && !gate_lvl) |-> line_driver_out == shift_stage)
		else $error("Open cells do not show the chain.");
	// Two closed edges in a row: the cells cannot have been written between them.
	closed_steady_a: assert property (@(posedge mclk) disable iff (!rst_n) // R05
		(!xfer_lvl && !gate_lvl) ##1 (!xfer_lvl && !gate_lvl) |-> $stable(line_driver_out))
		else $error("Closed cells changed the outputs.");
	// The value shown after the close is the chain seen at the last open edge.
	held_value_a: assert property (@(posedge mclk) disable iff (!rst_n) // R05
		(clk_en && xfer_lvl) ##1 (!xfer_lvl && !gate_lvl) |->
		line_driver_out == $past(shift_stage))
		else $error("Closed cells lost the value seen when they closed.");
	gate_force_a: assert property (@(posedge mclk) disable iff (!rst_n) // R06
		gate_lvl |-> line_driver_out == '0)
		else $error("High gate level did not force the outputs low.");
	// Each line has its own cell and gate, so a stage bit shows on its own line only.
	generate
		for (genvar j = 0; j < WIDTH; j++) begin : g_line
			line_map_a: assert property (@(posedge mclk) disable iff (!rst_n) // R01
				(xfer_lvl && !gate_lvl) |-> line_driver_out[j] == shift_stage[j])
				else $error("Line does not show its own stage.");
		end
	endgenerate

	// --------------------------------------------------------------
	// Floating input checks
	// --------------------------------------------------------------
	// Each pin is checked through its effect, not through the level wire that replaces it.
	float_high_a: assert property (@(posedge mclk) disable iff (!rst_n) // R08
		!gate_n_conn |-> line_driver_out == '0)
		else $error("Floating gate input not taken as high.");
	float_clk_a: assert property (@(posedge mclk) disable iff (!rst_n) // R08
		(clk_en && !shift_clk_conn) ##1 !shift_clk_conn |=> $stable(shift_stage))
		else $error("Floating clock pin still shifts.");
	float_data_a: assert property (@(posedge mclk) disable iff (!rst_n) // R08
		(clk_en && clk_rise && !serial_in_conn) |=> shift_stage[0])
		else $error("Floating data input not taken as high.");
	float_latch_a: assert property (@(posedge mclk) disable iff (!rst_n) // R08
		(!latch_xfer_conn && !gate_lvl) |-> line_driver_out == shift_stage)
		else $error("Floating transfer input did not open the cells.");

	// --------------------------------------------------------------
	// Coverage
	// --------------------------------------------------------------
	// A rise during a low enable shows the freeze was exercised, not only assumed.
	cover_shift_c: cover property (@(posedge mclk) clk_rise ##2 clk_rise ##2 clk_rise);
	cover_show_c: cover property (@(posedge mclk) xfer_lvl ##1 !xfer_lvl ##1 !gate_lvl);
	cover_float_c: cover property (@(posedge mclk) !serial_in_conn && clk_rise);
	cover_freeze_c: cover property (@(posedge mclk) !clk_en && clk_lvl && !clk_prev);
endmodule : ssld_top

// *** ssld_defs.svh ***
// Constants of the serial shift latch driver.
`ifndef SSLD_DEFS_SVH
`define SSLD_DEFS_SVH
`define SSLD_STAGES      12
`define SSLD_STAGE_RST   12'h000
`define SSLD_SYNC_RST    2'h0
`endif

// *** ssld_pkg.sv ***
// Types of the serial shift latch driver.
`include "ssld_defs.svh"
package ssld_pkg;
	typedef logic [`SSLD_STAGES-1:0] ssld_word_t;
endpackage : ssld_pkg

// *** ssld_if.sv ***
// Interface between the shift chain and the latch and gate stage.
`timescale 1ns/1ps
interface ssld_if #(parameter int WIDTH = 12);
	logic [WIDTH-1:0] stage;
	logic             latch_open;
	logic             gate_n;
	logic [WIDTH-1:0] drive;
	modport chain (output stage, output latch_open, output gate_n, input drive);
	modport latch (input stage, input latch_open, input gate_n, output drive);
endinterface : ssld_if

// *** ssld_latch.sv ***
// Storage cells and output gates of the serial shift latch driver.
`timescale 1ns/1ps
`include "ssld_defs.svh"
module ssld_latch
	import ssld_pkg::*;
#(
	parameter int WIDTH = `SSLD_STAGES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Link to the chain
	ssld_if.latch    lnk
);
	logic [WIDTH-1:0] storage_cell;
	logic [WIDTH-1:0] cell_view;

	// The cell is transparent in the same cycle so that output follows the stage.
	assign cell_view = lnk.latch_open ? lnk.stage : storage_cell; // R04
	assign lnk.drive = lnk.gate_n ? '0 : cell_view; // R06

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			storage_cell <= WIDTH'(`SSLD_STAGE_RST);
		end else if (clk_en && lnk.latch_open) begin
			storage_cell <= lnk.stage; // R05
		end
	end

	hold_cells_a: assert property (@(posedge mclk) disable iff (!rst_n) // R05
		(clk_en && !lnk.latch_open) |=> storage_cell == $past(storage_cell))
		else $error("Storage cells changed while closed.");
	gate_low_a: assert property (@(posedge mclk) disable iff (!rst_n) // R06
		lnk.gate_n |-> lnk.drive == '0)
		else $error("Outputs not forced low by gate.");
	gate_pass_a: assert property (@(posedge mclk) disable iff (!rst_n) // R06
		(!lnk.gate_n && !lnk.latch_open) |-> lnk.drive == storage_cell)
		else $error("Outputs do not show stored cells.");
	transparent_a: assert property (@(posedge mclk) disable iff (!rst_n) // R04
		(lnk.latch_open && !lnk.gate_n) |-> lnk.drive == lnk.stage)
		else $error("Open cells do not follow stages.");
	store_open_a: assert property (@(posedge mclk) disable iff (!rst_n) // R04
		(clk_en && lnk.latch_open) |=> storage_cell == $past(lnk.stage))
		else $error("Open cells did not keep the stage value.");
	cover_hold_c: cover property (@(posedge mclk) lnk.latch_open ##1 !lnk.latch_open [*3]);
endmodule : ssld_latch

// *** ssld_ctrl.sv ***
// Display controller model that feeds the serial side of the driver.
`timescale 1ns/1ps
module ssld_ctrl
	import ssld_pkg::*;
(
	// Clock
	input  wire logic mclk,
	// Controller pins
	output logic      shift_clk,
	output logic      serial_in,
	output logic      latch_xfer,
	output logic      gate_n
);
	initial begin
		shift_clk  = 1'b0;
		serial_in  = 1'b0;
		latch_xfer = 1'b0;
		gate_n     = 1'b0;
	end
	// --------------------------------------------------------------
	// Word transfer
	// --------------------------------------------------------------
	// The bit for the far output leaves first, so it ends at the last stage.
	task automatic send(input ssld_word_t w);
		for (int i = $bits(ssld_word_t) - 1; i >= 0; i--) begin
			@(posedge mclk);
			serial_in <= w[i];
			shift_clk <= 1'b0;
			@(posedge mclk);
			shift_clk <= 1'b1;
		end
		@(posedge mclk);
		shift_clk <= 1'b0;
	endtask : send
	// --------------------------------------------------------------
	// Transfer and gating levels
	// --------------------------------------------------------------
	task automatic set_latch(input logic v);
		@(posedge mclk);
		latch_xfer <= v;
	endtask : set_latch
	task automatic set_gate(input logic v);
		@(posedge mclk);
		gate_n <= v;
	endtask : set_gate
endmodule : ssld_ctrl

// *** ssld_top_tb.sv ***
// Testbench of the serial shift latch driver.
`timescale 1ns/1ps
module ssld_top_tb
	import ssld_pkg::*;
;
	logic       mclk = 1'b0;
	logic       nrst = 1'b0;
	logic       sck_c = 1'b1;
	logic       sin_c = 1'b1;
	logic       lx_c = 1'b1;
	logic       gn_c = 1'b1;
	logic       en = 1'b1;
	logic       sck, sin, lx, gn, cascade_out;
	ssld_word_t line_driver_out;
	int         err_count = 0;
	int         n_tests = 0;
	// --------------------------------------------------------------
	// Instances
	// --------------------------------------------------------------
	ssld_ctrl ssld_ctrl_inst (.mclk(mclk), .shift_clk(sck), .serial_in(sin),
		.latch_xfer(lx), .gate_n(gn));
	ssld_top ssld_top_inst (.mclk(mclk), .clk_en(en), .nrst(nrst), .shift_clk(sck),
		.shift_clk_conn(sck_c), .serial_in(sin), .serial_in_conn(sin_c),
		.latch_xfer(lx), .latch_xfer_conn(lx_c), .gate_n(gn), .gate_n_conn(gn_c),
		.line_driver_out(line_driver_out), .cascade_out(cascade_out));
	initial begin
		forever #20 mclk = ~mclk;
	end
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wt
	task automatic chk(input ssld_word_t got, input ssld_word_t exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	initial begin
		#200us;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		wt(4);
		ssld_ctrl_inst.send(12'hA5C);
		wt(2);
		chk(line_driver_out, 12'h000);
		chk({11'h000, cascade_out}, 12'h001);
		ssld_ctrl_inst.set_latch(1'b1);
		wt(2);
		chk(line_driver_out, 12'hA5C);
		$display("test shift and latch done");
		ssld_ctrl_inst.set_latch(1'b0);
		ssld_ctrl_inst.send(12'h3F1);
		wt(2);
		chk(line_driver_out, 12'hA5C);
		chk({11'h000, cascade_out}, 12'h000);
		ssld_ctrl_inst.set_gate(1'b1);
		wt(2);
		chk(line_driver_out, 12'h000);
		ssld_ctrl_inst.set_gate(1'b0);
		wt(2);
		chk(line_driver_out, 12'hA5C);
		$display("test hold and gating done");
		@(posedge mclk) en <= 1'b0;
		ssld_ctrl_inst.send(12'hFFF);
		wt(2);
		chk(line_driver_out, 12'hA5C);
		chk({11'h000, cascade_out}, 12'h000);
		@(posedge mclk) en <= 1'b1;
		$display("test clock enable done");
		@(posedge mclk) lx_c <= 1'b0;
		sin_c <= 1'b0;
		ssld_ctrl_inst.send(12'h000);
		wt(2);
		chk(line_driver_out, 12'hFFF);
		@(posedge mclk) gn_c <= 1'b0;
		wt(2);
		chk(line_driver_out, 12'h000);
		@(posedge mclk) gn_c <= 1'b1;
		sin_c <= 1'b1;
		sck_c <= 1'b0;
		ssld_ctrl_inst.send(12'hFFF);
		wt(2);
		// Releasing the low clock pin reads as one rise, which shifts in a zero.
		chk(line_driver_out, 12'hFFE);
		$display("test floating inputs done");
		finish_test();
	end
endmodule : ssld_top_tb
